// ---- design/mrd_operand_decoder.sv ----
// Registered decode of the addressing-form byte and scaled-index byte into operand recipes
// What this block does
// RULE1: Register form, word data, size bit set: word register numbered by the selector.
// RULE2: Register form, size bit clear: byte register, 000-011 low bytes, 100-111 high.
// RULE3: Register form, doubleword data, size bit set: doubleword register numbered by selector.
// RULE4: Register field decodes with the same mapping as the register-form selector.
// RULE5: Form 00 without index byte: register base, data segment; selector 101 is absolute long.
// RULE6: Forms 01/10 add short/long offset; base 101 defaults to stack segment.
// RULE7: Selector 100 with forms 00, 01, 10 announces a scaled-index byte; the code takes it as one only while i_addr32 is set.
// RULE8: Index-byte base 100 selects stack pointer base, stack segment, all memory forms.
// RULE9: Index-byte form 00 base 101: no base, long offset plus scaled index, data segment.
// RULE10: Index-byte form 01 base 101: frame pointer, scaled index, short offset, stack segment.
// RULE11: Index-byte form 10: base plus scaled index plus long offset; 101 uses stack segment.
// RULE12: Index-byte other bases select that register, data segment; 00 none, 01 short offset.
// RULE13: Scale codes 00, 01, 10, 11 multiply the index by 1, 2, 4, 8.
// RULE14: Index 100 means no index; the stream must then carry scale code 00.
// RULE15: A short offset is sign-extended to full width before address generation.
`timescale 1ns/1ps
`default_nettype none

module mrd_operand_decoder #(
  parameter int unsigned DISP_W = 32
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_valid,
  input wire logic [7:0] i_modrm,
  input wire logic [7:0] i_sib,
  input wire logic i_opsize,
  input wire logic i_data32,
  input wire logic i_addr32,
  input wire logic [7:0] i_short_offset,
  input wire logic [DISP_W-1:0] i_long_offset,
  output logic o_valid,
  output logic o_is_reg,
  output var mrd_pkg::mrd_class_t o_rm_class,
  output logic [2:0] o_rm_num,
  output var mrd_pkg::mrd_class_t o_reg_class,
  output logic [2:0] o_reg_num,
  output logic o_sib_used,
  output logic o_base_valid,
  output logic [2:0] o_base_num,
  output logic o_index_valid,
  output logic [2:0] o_index_num,
  output logic [1:0] o_scale_shift,
  output var mrd_pkg::mrd_disp_t o_disp_kind,
  output logic [DISP_W-1:0] o_disp,
  output var mrd_pkg::mrd_seg_t o_seg,
  output logic o_ea_undefined,
  output logic o_addr16_form
);
  import mrd_pkg::*;

  // Offsets narrower than a short offset cannot hold its sign extension
  if (DISP_W < SHORT_OFFSET_W || DISP_W > LONG_OFFSET_W) begin : g_bad_width
    $error("DISP_W must lie between the short and long offset widths");
  end

  typedef struct packed {
    logic valid;
    logic is_reg;
    mrd_class_t rm_class;
    logic [2:0] rm_num;
    mrd_class_t reg_class;
    logic [2:0] reg_num;
    logic sib_used;
    logic base_valid;
    logic [2:0] base_num;
    logic index_valid;
    logic [2:0] index_num;
    logic [1:0] scale_shift;
    mrd_disp_t disp_kind;
    logic [DISP_W-1:0] disp;
    mrd_seg_t seg;
    logic ea_undefined;
    logic addr16_form;
  } mrd_state_t;

  mrd_state_t state_reg;
  mrd_state_t state_next;

  logic [1:0] form;
  logic [2:0] sel;
  logic [2:0] reg_sel;
  logic [1:0] sib_scale;
  logic [2:0] sib_index;
  logic [2:0] sib_base;

  assign form = i_modrm[MODRM_MOD_LSB +: FORM_W];
  assign sel = i_modrm[MODRM_RM_LSB +: SEL_W];
  assign reg_sel = i_modrm[MODRM_REG_LSB +: SEL_W];
  assign sib_scale = i_sib[SIB_SCALE_LSB +: SCALE_W];
  assign sib_index = i_sib[SIB_INDEX_LSB +: SEL_W];
  assign sib_base = i_sib[SIB_BASE_LSB +: SEL_W];

  always_comb begin
    mrd_class_t size_class;
    logic [2:0] base_code;
    size_class = RC_BYTE;
    base_code = sel;
    state_next = '0;
    state_next.valid = i_valid;
    if (i_valid) begin
      // Size bit clear always means a byte register; byte codes 100-111 are the high bytes
      if (!i_opsize) begin
        size_class = RC_BYTE; // RULE2
      end else if (i_data32) begin
        size_class = RC_DWORD; // RULE3
      end else begin
        size_class = RC_WORD; // RULE1
      end
      state_next.reg_class = size_class; // RULE4
      state_next.reg_num = reg_sel; // RULE4
      if (form == FORM_REGISTER) begin
        state_next.is_reg = 1'b1;
        state_next.rm_class = size_class; // RULE1 RULE2 RULE3
        state_next.rm_num = sel; // RULE1 RULE2 RULE3
      end else if (!i_addr32) begin
        // Word addressing memory forms are resolved elsewhere
        state_next.addr16_form = 1'b1;
      end else begin
        if (sel == SEL_SIB_FOLLOWS) begin
          state_next.sib_used = 1'b1; // RULE7
          base_code = sib_base;
          state_next.index_valid = (sib_index != INDEX_NONE); // RULE14
          state_next.index_num = sib_index;
          state_next.scale_shift = sib_scale; // RULE13
          // Flagged only; the address is left to the stream's own discipline
          state_next.ea_undefined = (sib_index == INDEX_NONE) && (sib_scale != SCALE_BY_ONE); // RULE14
          if (base_code == BASE_STACK_PTR) begin
            state_next.seg = SEG_STACK; // RULE8
          end
        end
        state_next.base_valid = 1'b1; // RULE5 RULE12
        state_next.base_num = base_code; // RULE12
        if (form == FORM_NO_OFFSET && base_code == SEL_ABSOLUTE) begin
          // Absolute form: no base, long offset, data segment
          state_next.base_valid = 1'b0; // RULE5 RULE9
          state_next.disp_kind = DISP_LONG; // RULE5 RULE9
        end else if (form == FORM_SHORT_OFFSET) begin
          state_next.disp_kind = DISP_SHORT; // RULE6 RULE10 RULE12
        end else if (form == FORM_LONG_OFFSET) begin
          state_next.disp_kind = DISP_LONG; // RULE6 RULE11
        end
        if (form != FORM_NO_OFFSET && base_code == BASE_FRAME_PTR) begin
          state_next.seg = SEG_STACK; // RULE6 RULE10 RULE11
        end
      end
      if (state_next.disp_kind == DISP_SHORT) begin
        state_next.disp = {{(DISP_W - SHORT_OFFSET_W){i_short_offset[SHORT_OFFSET_W-1]}}, i_short_offset}; // RULE15
      end else if (state_next.disp_kind == DISP_LONG) begin
        state_next.disp = i_long_offset;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_valid = state_reg.valid;
  assign o_is_reg = state_reg.is_reg;
  assign o_rm_class = state_reg.rm_class;
  assign o_rm_num = state_reg.rm_num;
  assign o_reg_class = state_reg.reg_class;
  assign o_reg_num = state_reg.reg_num;
  assign o_sib_used = state_reg.sib_used;
  assign o_base_valid = state_reg.base_valid;
  assign o_base_num = state_reg.base_num;
  assign o_index_valid = state_reg.index_valid;
  assign o_index_num = state_reg.index_num;
  assign o_scale_shift = state_reg.scale_shift;
  assign o_disp_kind = state_reg.disp_kind;
  assign o_disp = state_reg.disp;
  assign o_seg = state_reg.seg;
  assign o_ea_undefined = state_reg.ea_undefined;
  assign o_addr16_form = state_reg.addr16_form;

  // Checks: each output one cycle after the fields that caused it
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  logic mem32;
  assign mem32 = i_valid && i_addr32 && (form != FORM_REGISTER);

  property p_word_reg;
    i_valid && form == FORM_REGISTER && i_opsize && !i_data32
      |=> o_is_reg && o_rm_class == RC_WORD && o_rm_num == $past(sel);
  endproperty
  a_word_reg: assert property (p_word_reg) else $error("word register form misdecoded"); // RULE1

  property p_byte_reg;
    i_valid && form == FORM_REGISTER && !i_opsize
      |=> o_is_reg && o_rm_class == RC_BYTE && o_rm_num == $past(sel);
  endproperty
  a_byte_reg: assert property (p_byte_reg) else $error("byte register form misdecoded"); // RULE2

  property p_dword_reg;
    i_valid && form == FORM_REGISTER && i_opsize && i_data32
      |=> o_is_reg && o_rm_class == RC_DWORD && o_rm_num == $past(sel);
  endproperty
  a_dword_reg: assert property (p_dword_reg) else $error("doubleword register form misdecoded"); // RULE3

  // Checked for memory forms too, since the register field is always decoded
  property p_reg_field;
    o_valid |-> o_reg_num == $past(reg_sel)
      && o_reg_class == (!$past(i_opsize) ? RC_BYTE : ($past(i_data32) ? RC_DWORD : RC_WORD));
  endproperty
  a_reg_field: assert property (p_reg_field) else $error("register field mapping differs"); // RULE4

  property p_form0_plain;
    mem32 && form == FORM_NO_OFFSET && sel != SEL_SIB_FOLLOWS
      |=> o_disp_kind == (($past(sel) == SEL_ABSOLUTE) ? DISP_LONG : DISP_NONE)
          && o_base_valid == ($past(sel) != SEL_ABSOLUTE) && o_seg == SEG_DATA;
  endproperty
  a_form0_plain: assert property (p_form0_plain) else $error("form 00 without index byte wrong"); // RULE5

  property p_offset_plain;
    mem32 && form != FORM_NO_OFFSET && sel != SEL_SIB_FOLLOWS
      |=> o_base_valid && o_base_num == $past(sel)
          && o_seg == (($past(sel) == BASE_FRAME_PTR) ? SEG_STACK : SEG_DATA)
          && o_disp_kind == (($past(form) == FORM_SHORT_OFFSET) ? DISP_SHORT : DISP_LONG);
  endproperty
  a_offset_plain: assert property (p_offset_plain) else $error("offset form without index byte wrong"); // RULE6

  property p_sib_flag;
    i_valid && form != FORM_REGISTER |=> o_sib_used == ($past(i_addr32) && $past(sel) == SEL_SIB_FOLLOWS);
  endproperty
  a_sib_flag: assert property (p_sib_flag) else $error("index byte presence wrong"); // RULE7

  property p_sib_stack;
    mem32 && sel == SEL_SIB_FOLLOWS && sib_base == BASE_STACK_PTR
      |=> o_base_valid && o_base_num == BASE_STACK_PTR && o_seg == SEG_STACK;
  endproperty
  a_sib_stack: assert property (p_sib_stack) else $error("stack base in index byte wrong"); // RULE8

  property p_sib_abs;
    mem32 && sel == SEL_SIB_FOLLOWS && sib_base == BASE_FRAME_PTR && form == FORM_NO_OFFSET
      |=> !o_base_valid && o_disp_kind == DISP_LONG && o_disp == $past(i_long_offset) && o_seg == SEG_DATA;
  endproperty
  a_sib_abs: assert property (p_sib_abs) else $error("absolute index byte form wrong"); // RULE9

  property p_sib_frame;
    mem32 && sel == SEL_SIB_FOLLOWS && sib_base == BASE_FRAME_PTR && form != FORM_NO_OFFSET
      |=> o_base_valid && o_base_num == BASE_FRAME_PTR && o_seg == SEG_STACK
          && o_disp_kind == (($past(form) == FORM_SHORT_OFFSET) ? DISP_SHORT : DISP_LONG);
  endproperty
  a_sib_frame: assert property (p_sib_frame) else $error("frame base in index byte wrong"); // RULE10 RULE11

  property p_sib_other;
    mem32 && sel == SEL_SIB_FOLLOWS && sib_base != BASE_STACK_PTR && sib_base != BASE_FRAME_PTR
      |=> o_base_valid && o_base_num == $past(sib_base) && o_seg == SEG_DATA
          && o_disp_kind == (($past(form) == FORM_NO_OFFSET) ? DISP_NONE
          : (($past(form) == FORM_SHORT_OFFSET) ? DISP_SHORT : DISP_LONG));
  endproperty
  a_sib_other: assert property (p_sib_other) else $error("general base in index byte wrong"); // RULE12

  property p_scale;
    mem32 && sel == SEL_SIB_FOLLOWS
      |=> o_scale_shift == $past(sib_scale) && o_index_valid == ($past(sib_index) != INDEX_NONE);
  endproperty
  a_scale: assert property (p_scale) else $error("scale or index wrong"); // RULE13

  property p_sign_ext;
    o_valid && o_disp_kind == DISP_SHORT
      |-> o_disp == DISP_W'($signed($past(i_short_offset)));
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("short offset not sign-extended"); // RULE15

  property p_long_pass;
    o_valid && o_disp_kind == DISP_LONG |-> o_disp == $past(i_long_offset);
  endproperty
  a_long_pass: assert property (p_long_pass) else $error("long offset not passed through"); // RULE6 RULE11

  property p_disp_none;
    o_valid && o_disp_kind == DISP_NONE |-> o_disp == '0;
  endproperty
  a_disp_none: assert property (p_disp_none) else $error("offset present without offset form"); // RULE5 RULE12

  // Word addressing is left to another decoder, so nothing of the 32-bit recipe may leak out
  property p_addr16;
    i_valid && !i_addr32 && form != FORM_REGISTER
      |=> o_addr16_form && !o_base_valid && !o_sib_used && o_disp_kind == DISP_NONE;
  endproperty
  a_addr16: assert property (p_addr16) else $error("word addressing form not isolated"); // RULE7

  // The decoder only flags a broken stream; it cannot repair the address
  property p_ea_flag;
    mem32 && sel == SEL_SIB_FOLLOWS
      |=> o_ea_undefined == ($past(sib_index) == INDEX_NONE && $past(sib_scale) != SCALE_BY_ONE);
  endproperty
  a_ea_flag: assert property (p_ea_flag) else $error("undefined address flag wrong"); // RULE14

  c_reg_form: cover property (i_valid && form == FORM_REGISTER ##1 o_is_reg);
  c_sib_form: cover property (mem32 && sel == SEL_SIB_FOLLOWS ##1 o_sib_used && o_index_valid);
  c_abs_form: cover property (mem32 && sel == SEL_ABSOLUTE && form == FORM_NO_OFFSET ##1 !o_base_valid);
  c_stack_seg: cover property (o_valid && o_seg == SEG_STACK && o_disp_kind == DISP_SHORT);
  c_sib_long: cover property (mem32 && sel == SEL_SIB_FOLLOWS && form == FORM_LONG_OFFSET ##1 o_disp_kind == DISP_LONG);

endmodule : mrd_operand_decoder

`default_nettype wire

// ---- design/mrd_pkg.sv ----
// Shared constants and types for the operand-specifier decoder
package mrd_pkg;

  // Field positions inside the addressing-form byte
  localparam int MODRM_MOD_LSB = 6;
  localparam int MODRM_REG_LSB = 3;
  localparam int MODRM_RM_LSB = 0;

  // Field positions inside the scaled-index byte
  localparam int SIB_SCALE_LSB = 6;
  localparam int SIB_INDEX_LSB = 3;
  localparam int SIB_BASE_LSB = 0;

  // Field widths
  localparam int FORM_W = 2;
  localparam int SEL_W = 3;
  localparam int SCALE_W = 2;
  localparam int BYTE_W = 8;
  localparam int LONG_OFFSET_W = 32;
  localparam int SHORT_OFFSET_W = 8;

  // Addressing-form codes
  localparam logic [1:0] FORM_NO_OFFSET = 2'h0;
  localparam logic [1:0] FORM_SHORT_OFFSET = 2'h1;
  localparam logic [1:0] FORM_LONG_OFFSET = 2'h2;
  localparam logic [1:0] FORM_REGISTER = 2'h3;

  // Special selector codes
  localparam logic [2:0] SEL_SIB_FOLLOWS = 3'h4;
  localparam logic [2:0] SEL_ABSOLUTE = 3'h5;
  localparam logic [2:0] BASE_STACK_PTR = 3'h4;
  localparam logic [2:0] BASE_FRAME_PTR = 3'h5;
  localparam logic [2:0] INDEX_NONE = 3'h4;
  localparam logic [1:0] SCALE_BY_ONE = 2'h0;

  // Operand width class of a register operand
  typedef enum logic [1:0] {
    RC_BYTE,
    RC_WORD,
    RC_DWORD
  } mrd_class_t;

  // Displacement carried by the instruction
  typedef enum logic [1:0] {
    DISP_NONE,
    DISP_SHORT,
    DISP_LONG
  } mrd_disp_t;

  // Default segment of a memory operand
  typedef enum logic {
    SEG_DATA,
    SEG_STACK
  } mrd_seg_t;

endpackage : mrd_pkg

// ---- testbench/mrd_fetch_model.sv ----
// Instruction-stream model that hands the scaled-index byte to the decoder
`timescale 1ns/1ps
`default_nettype none

module mrd_fetch_model (
  input wire logic [7:0] i_sib_raw,
  input wire logic i_strict,
  output logic [7:0] o_sib
);
  import mrd_pkg::*;

  // A well-formed stream carries scale 00 with no index; clearing i_strict lets a scenario break this
  always_comb begin
    o_sib = i_sib_raw;
    if (i_strict && i_sib_raw[5:3] == INDEX_NONE) begin
      o_sib = {SCALE_BY_ONE, i_sib_raw[5:0]};
    end
  end
endmodule : mrd_fetch_model

`default_nettype wire

// ---- testbench/mrd_operand_decoder_tb.sv ----
// Self-checking bench for the operand-specifier decoder
`timescale 1ns/1ps
`default_nettype none

module mrd_operand_decoder_tb;
  import mrd_pkg::*;
  typedef struct packed {
    logic [7:0] m; logic [7:0] s; logic op; logic d; logic sb; logic bv;
    logic [2:0] bn; logic iv; logic [1:0] sc; mrd_disp_t dk; mrd_seg_t sg;
  } mrd_row_t;
  localparam logic [7:0] SHORT_V = 8'h80;
  localparam logic [31:0] LONG_V = 32'h1234_5678;
  localparam int N = 23;
  logic i_clock = 1'b0, i_sys_rst = 1'b1, i_valid = 1'b0, i_opsize = 1'b0, i_data32 = 1'b0, i_addr32 = 1'b1;
  logic strict = 1'b1;
  logic [7:0] i_modrm = 8'h00, sib_raw = 8'h00, i_sib, i_short_offset = SHORT_V;
  logic [31:0] i_long_offset = LONG_V, o_disp;
  logic o_valid, o_is_reg, o_sib_used, o_base_valid, o_index_valid, o_ea_undefined, o_addr16_form;
  logic [2:0] o_rm_num, o_reg_num, o_base_num, o_index_num;
  logic [1:0] o_scale_shift;
  mrd_class_t o_rm_class, o_reg_class;
  mrd_disp_t o_disp_kind;
  mrd_seg_t o_seg;
  int fails = 0, n_tests = 0;
  logic [57:0] row_seen, row_want;
  mrd_row_t rows [N] = '{
    '{8'hC3,8'hFF,1'b1,1'b0,1'b0,1'b0,3'h0,1'b0,2'h0,DISP_NONE,SEG_DATA},
    '{8'hFF,8'hFF,1'b1,1'b0,1'b0,1'b0,3'h0,1'b0,2'h0,DISP_NONE,SEG_DATA},
    '{8'hC4,8'hFF,1'b0,1'b0,1'b0,1'b0,3'h0,1'b0,2'h0,DISP_NONE,SEG_DATA},
    '{8'hD3,8'hFF,1'b0,1'b1,1'b0,1'b0,3'h0,1'b0,2'h0,DISP_NONE,SEG_DATA},
    '{8'hC0,8'hFF,1'b1,1'b1,1'b0,1'b0,3'h0,1'b0,2'h0,DISP_NONE,SEG_DATA},
    '{8'hEF,8'hFF,1'b1,1'b1,1'b0,1'b0,3'h0,1'b0,2'h0,DISP_NONE,SEG_DATA},
    '{8'h00,8'hFF,1'b1,1'b1,1'b0,1'b1,3'h0,1'b0,2'h0,DISP_NONE,SEG_DATA},
    '{8'h05,8'hFF,1'b1,1'b1,1'b0,1'b0,3'h5,1'b0,2'h0,DISP_LONG,SEG_DATA},
    '{8'h07,8'hFF,1'b1,1'b1,1'b0,1'b1,3'h7,1'b0,2'h0,DISP_NONE,SEG_DATA},
    '{8'h45,8'hFF,1'b1,1'b1,1'b0,1'b1,3'h5,1'b0,2'h0,DISP_SHORT,SEG_STACK},
    '{8'h85,8'hFF,1'b1,1'b1,1'b0,1'b1,3'h5,1'b0,2'h0,DISP_LONG,SEG_STACK},
    '{8'h41,8'hFF,1'b1,1'b1,1'b0,1'b1,3'h1,1'b0,2'h0,DISP_SHORT,SEG_DATA},
    '{8'h82,8'hFF,1'b1,1'b1,1'b0,1'b1,3'h2,1'b0,2'h0,DISP_LONG,SEG_DATA},
    '{8'h04,8'h4C,1'b1,1'b1,1'b1,1'b1,3'h4,1'b1,2'h1,DISP_NONE,SEG_STACK},
    '{8'h44,8'h8C,1'b1,1'b1,1'b1,1'b1,3'h4,1'b1,2'h2,DISP_SHORT,SEG_STACK},
    '{8'h84,8'hCC,1'b1,1'b1,1'b1,1'b1,3'h4,1'b1,2'h3,DISP_LONG,SEG_STACK},
    '{8'h04,8'h95,1'b1,1'b1,1'b1,1'b0,3'h5,1'b1,2'h2,DISP_LONG,SEG_DATA},
    '{8'h44,8'h1D,1'b1,1'b1,1'b1,1'b1,3'h5,1'b1,2'h0,DISP_SHORT,SEG_STACK},
    '{8'h84,8'h1D,1'b1,1'b1,1'b1,1'b1,3'h5,1'b1,2'h0,DISP_LONG,SEG_STACK},
    '{8'h84,8'h30,1'b1,1'b1,1'b1,1'b1,3'h0,1'b1,2'h0,DISP_LONG,SEG_DATA},
    '{8'h04,8'h36,1'b1,1'b1,1'b1,1'b1,3'h6,1'b1,2'h0,DISP_NONE,SEG_DATA},
    '{8'h44,8'h3B,1'b1,1'b1,1'b1,1'b1,3'h3,1'b1,2'h0,DISP_SHORT,SEG_DATA},
    '{8'h04,8'h20,1'b1,1'b1,1'b1,1'b1,3'h0,1'b0,2'h0,DISP_NONE,SEG_DATA}
  };

  mrd_fetch_model fetch_u (.i_sib_raw(sib_raw), .i_strict(strict), .o_sib(i_sib));
  mrd_operand_decoder #(.DISP_W(32)) dut_u (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_valid(i_valid), .i_modrm(i_modrm), .i_sib(i_sib),
    .i_opsize(i_opsize), .i_data32(i_data32), .i_addr32(i_addr32), .i_short_offset(i_short_offset),
    .i_long_offset(i_long_offset), .o_valid(o_valid), .o_is_reg(o_is_reg), .o_rm_class(o_rm_class),
    .o_rm_num(o_rm_num), .o_reg_class(o_reg_class), .o_reg_num(o_reg_num), .o_sib_used(o_sib_used),
    .o_base_valid(o_base_valid), .o_base_num(o_base_num), .o_index_valid(o_index_valid),
    .o_index_num(o_index_num), .o_scale_shift(o_scale_shift), .o_disp_kind(o_disp_kind), .o_disp(o_disp),
    .o_seg(o_seg), .o_ea_undefined(o_ea_undefined), .o_addr16_form(o_addr16_form));

  always #5 i_clock = ~i_clock;

  // Memory forms must leave the selector register number at zero
  function automatic logic [57:0] seen_vec();
    return {o_valid, o_is_reg, o_rm_class, o_rm_num, o_reg_class, o_reg_num, o_sib_used,
      o_base_valid, o_base_num, o_index_valid, o_index_num, o_scale_shift, o_disp_kind, o_seg, o_disp};
  endfunction : seen_vec

  function automatic logic [57:0] exp_vec(input mrd_row_t r);
    mrd_class_t cls;
    logic isr;
    logic [31:0] dsp;
    cls = !r.op ? RC_BYTE : (r.d ? RC_DWORD : RC_WORD);
    isr = (r.m[7:6] == FORM_REGISTER);
    dsp = (r.dk == DISP_SHORT) ? {{24{SHORT_V[7]}}, SHORT_V} : ((r.dk == DISP_LONG) ? LONG_V : 32'h0000_0000);
    return {1'b1, isr, (isr ? cls : RC_BYTE), (isr ? r.m[2:0] : 3'h0), cls, r.m[5:3], r.sb, r.bv, r.bn,
      r.iv, (r.sb ? r.s[5:3] : 3'h0), r.sc, r.dk, r.sg, dsp};
  endfunction : exp_vec

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (12) @(posedge i_clock);
    @(negedge i_clock);
    check(64'(seen_vec()), 64'h0);
    i_sys_rst = 1'b0;
    for (int i = 0; i < N; i++) begin
      i_valid = 1'b1;
      i_modrm = rows[i].m;
      sib_raw = rows[i].s;
      i_opsize = rows[i].op;
      i_data32 = rows[i].d;
      @(negedge i_clock);
      row_seen = seen_vec();
      row_want = exp_vec(rows[i]);
      check(64'(row_seen[57:46]), 64'(row_want[57:46]));
      check(64'(row_seen[45:0]), 64'(row_want[45:0]));
    end
    i_valid = 1'b0;
    @(negedge i_clock);
    check(64'(seen_vec()), 64'h0);
    // A second reset in mid-run must swallow a pending request
    i_valid = 1'b1;
    i_modrm = 8'hC3;
    i_sys_rst = 1'b1;
    @(negedge i_clock);
    check(64'({o_valid, o_is_reg}), 64'h0);
    i_sys_rst = 1'b0;
    // Memory forms under 16-bit addressing are only flagged
    i_addr32 = 1'b0;
    i_modrm = 8'h84;
    @(negedge i_clock);
    check(64'({o_addr16_form, o_base_valid, o_sib_used, o_disp_kind}), 64'h10);
    i_addr32 = 1'b1;
    // No index with a nonzero scale is flagged; a well-formed stream clears the scale
    i_modrm = 8'h04;
    sib_raw = 8'h60;
    strict = 1'b0;
    @(negedge i_clock);
    strict = 1'b1;
    check(64'({o_ea_undefined, o_index_valid, o_sib_used}), 64'h5);
    @(negedge i_clock);
    check(64'({o_ea_undefined, o_scale_shift, o_index_valid}), 64'h0);
    finish_test();
  end

  initial begin
    repeat (500) @(posedge i_clock);
    fails++;
    finish_test();
  end
endmodule : mrd_operand_decoder_tb

`default_nettype wire
